//--- sim/jerk_limited_accel_profiler_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench top
module jerk_limited_accel_profiler_bench;
  localparam int TDIV = 16; // Short update period keeps runs brief
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic step_pulse;
  logic [19:0] step_rate;
  logic busy;
  int err_count = 0;
  int checks_done = 0;
  int seed = 32'h9db1b83a;
  int dur_q[$];
  int vt;
  int first;
  int dur;
  logic [31:0] rv;
  logic [31:0] st;
  // Clock at 20 MHz
  always #25 clk = ~clk;
  jlp_profiler #(.TICK_DIV(TDIV)) u_jlp_profiler (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .step_pulse(step_pulse), .step_rate(step_rate), .busy(busy));
  jlp_host u_jlp_host (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .step_pulse(step_pulse));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  // Slack of 3 percent and a few updates covers tick phase
  task automatic near(input int seen, input real exp);
    check(32'(seen > exp * 0.97 - 4 * TDIV && seen < exp * 1.03 + 4 * TDIV),
      32'h1);
  endtask
  // Expected phase length in cycles from the shape formulas
  function automatic real t_exp(input int a, input int jp, input int dv);
    real j;
    real t;
    j = real'((jp * a) / 100);
    if (jp == 0) t = real'(dv) / a;
    else if (j * dv > real'(a) * a) t = real'(a) / j + real'(dv) / a;
    else t = 2.0 * $sqrt(real'(dv) / j);
    return t * 1024.0 * TDIV;
  endfunction
  // One speed change: length in cycles and status while it runs
  task automatic move(input logic [31:0] cmd, output int n,
    output logic [31:0] s);
    n = 0;
    first = 0;
    u_jlp_host.wr(jlp_pkg::OFS_CTRL, cmd);
    for (int i = 0; i < 8 && busy !== 1'b1; i++) begin
      @(posedge clk);
    end
    u_jlp_host.rd(jlp_pkg::OFS_STATUS, s);
    // Only this task writes first: the first nonzero speed of the phase
    while (busy === 1'b1) begin
      @(posedge clk);
      n++;
      if (first == 0) first = int'(step_rate);
    end
    @(posedge clk);
  endtask
  task automatic close_out;
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog against a hung phase; the tests need about 70k cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    close_out;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(step_rate, 32'h0);
    u_jlp_host.rd(jlp_pkg::OFS_ACCEL, rv);
    check(rv, jlp_pkg::RST_ACCEL);
    u_jlp_host.rd(jlp_pkg::OFS_JERK, rv);
    check(rv, jlp_pkg::RST_JERK);
    // Constant acceleration to a random goal
    vt = 1000 + ($random(seed) & 32'hfff);
    u_jlp_host.wr(jlp_pkg::OFS_ACCEL, 32'd58000);
    u_jlp_host.wr(jlp_pkg::OFS_VTARGET, 32'(vt));
    move(32'h1, dur, st);
    check(first, (58000 * 1024) >> 20);
    near(dur, t_exp(58000, 0, vt));
    check(step_rate, vt);
    // Jerk-limited stop at twice the rate
    u_jlp_host.wr(jlp_pkg::OFS_DECEL, 32'd116000);
    u_jlp_host.wr(jlp_pkg::OFS_JERK, 32'd400);
    move(32'h2, dur, st);
    check(st[jlp_pkg::STAT_DOWN_BIT], 1'b1);
    near(dur, t_exp(116000, 400, vt));
    check(step_rate, 32'h0);
    // Trapezoid with a hold at the cap
    u_jlp_host.wr(jlp_pkg::OFS_DECEL, 32'd58000);
    u_jlp_host.wr(jlp_pkg::OFS_VTARGET, 32'd30000);
    move(32'h1, dur, st);
    check(32'(first < 56), 32'h1);
    near(dur, t_exp(58000, 400, 30000));
    u_jlp_host.rd(jlp_pkg::OFS_STATUS, rv);
    check(rv[jlp_pkg::STAT_TRAP_BIT], 1'b1);
    u_jlp_host.rd(jlp_pkg::OFS_SPEED, rv);
    check(rv, 32'd30000);
    dur_q.push_back(dur);
    // Driver sees 30 steps per millisecond at full speed
    u_jlp_host.steps = 0;
    repeat (20000) @(posedge clk);
    check(32'(u_jlp_host.steps >= 29 && u_jlp_host.steps <= 31), 32'h1);
    // Equal rates mirror the phase on the way down
    move(32'h2, dur, st);
    near(dur, real'(dur_q[0]));
    // Low jerk meets the midpoint below the cap
    u_jlp_host.wr(jlp_pkg::OFS_JERK, 32'd20);
    u_jlp_host.wr(jlp_pkg::OFS_VTARGET, 32'd3000);
    move(32'h1, dur, st);
    near(dur, t_exp(58000, 20, 3000));
    u_jlp_host.rd(jlp_pkg::OFS_STATUS, rv);
    check(rv[jlp_pkg::STAT_TRAP_BIT], 1'b0);
    // Host picks jerk as 200/t for a 0.1 s triangular phase
    u_jlp_host.wr(jlp_pkg::OFS_JERK, 32'd2000);
    u_jlp_host.wr(jlp_pkg::OFS_VTARGET, 32'd5900);
    move(32'h1, dur, st);
    near(dur, 200.0 / 2000 * 1024.0 * TDIV);
    check(step_rate, 32'd5900);
    // Host picks jerk as 400/t for a half-constant 0.1 s trapezoid
    u_jlp_host.wr(jlp_pkg::OFS_JERK, 32'd4000);
    u_jlp_host.wr(jlp_pkg::OFS_VTARGET, 32'd10250);
    move(32'h1, dur, st);
    near(dur, 400.0 / 4000 * 1024.0 * TDIV);
    u_jlp_host.rd(jlp_pkg::OFS_STATUS, rv);
    check(rv[jlp_pkg::STAT_TRAP_BIT], 1'b1);
    // Status ignores writes and control reads back zero
    u_jlp_host.wr(jlp_pkg::OFS_STATUS, 32'hffff_ffff);
    u_jlp_host.rd(jlp_pkg::OFS_STATUS, rv);
    check(rv[jlp_pkg::STAT_BUSY_BIT], 1'b0);
    u_jlp_host.rd(jlp_pkg::OFS_CTRL, rv);
    check(rv, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire

//--- sim/jlp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host register master and stepper driver pulse counter
module jlp_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [2:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Driver side
  input wire logic step_pulse
);
  int steps = 0;
  // Idle bus from time zero
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Driver counts each step pulse
  always @(posedge clk) begin
    if (step_pulse === 1'b1) steps <= steps + 1;
  end
  // Strobe for one cycle; the gap edge avoids a double assignment
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // Read data stands only in the cycle after the strobe; taken at the
  // edge that closes that cycle, before the port clears it
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- verilog/jlp_pkg.sv
`default_nettype none
package jlp_pkg;
  // ==========================================================
  // Clock and update timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  // Profile updates run at 2**TICK_SHIFT per second, nominal
  localparam int TICK_SHIFT = 10;
  // Longest period rounds down to whole cycles
  localparam int TICK_DIV = CLK_HZ >> TICK_SHIFT;
  // Jerk parameter is in hundredths of acceleration per second
  localparam int JERK_SCALE = 100;

  // ==========================================================
  // Register offsets (word index on the plain register port)
  localparam logic [2:0] OFS_ACCEL = 3'h0;
  localparam logic [2:0] OFS_DECEL = 3'h1;
  localparam logic [2:0] OFS_JERK = 3'h2;
  localparam logic [2:0] OFS_VSTART = 3'h3;
  localparam logic [2:0] OFS_VTARGET = 3'h4;
  localparam logic [2:0] OFS_CTRL = 3'h5;
  localparam logic [2:0] OFS_STATUS = 3'h6;
  localparam logic [2:0] OFS_SPEED = 3'h7;

  // Field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TRAP_BIT = 1;
  localparam int STAT_DOWN_BIT = 2;

  // Reset values
  localparam logic [31:0] RST_ACCEL = 32'h0000_0000;
  localparam logic [31:0] RST_JERK = 32'h0000_0000;
  localparam logic [31:0] RST_SPEED = 32'h0000_0000;

  typedef enum {
    JLP_IDLE,
    JLP_LOAD,
    JLP_CONST,
    JLP_UP,
    JLP_HOLD,
    JLP_DOWN
  } jlp_state_t;
endpackage
`default_nettype wire

//--- verilog/jlp_profiler.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module jlp_profiler #(
  parameter int AW = 24,
  parameter int VW = 20,
  parameter int JW = 16,
  parameter int TICK_DIV = jlp_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Motion outputs
  output logic step_pulse,
  output logic [VW-1:0] step_rate,
  output logic busy
);
  localparam int PW = 48;
  localparam int SH = 2 * jlp_pkg::TICK_SHIFT;
  localparam int PH = 26;

  jlp_pkg::jlp_state_t state_r;
  logic [AW-1:0] accel_r, decel_r;
  logic [JW-1:0] jerk_r;
  logic [VW-1:0] vstart_r, vtarget_r, goal_r;
  logic go_r, dir_dn_r, trap_r, tick;
  logic [PW-1:0] j_r, amax_r, acc_r, prog_r, dv_r, half_r, p1_r, base_r;
  logic [PW-1:0] spd_s;
  logic [AW-1:0] rate_sel;
  logic [JW+AW-1:0] jprod;
  logic [PH-1:0] ph_r;

  jlp_tick #(.DIV(TICK_DIV)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ==========================================================
  // Register writes; go/stop are one-cycle commands
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accel_r <= AW'(jlp_pkg::RST_ACCEL);
      decel_r <= AW'(jlp_pkg::RST_ACCEL);
      jerk_r <= JW'(jlp_pkg::RST_JERK);
      vstart_r <= VW'(jlp_pkg::RST_SPEED);
      vtarget_r <= VW'(jlp_pkg::RST_SPEED);
      goal_r <= VW'(jlp_pkg::RST_SPEED);
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (reg_wr) begin
        unique case (reg_addr)
          jlp_pkg::OFS_ACCEL: accel_r <= reg_wdata[AW-1:0];
          jlp_pkg::OFS_DECEL: decel_r <= reg_wdata[AW-1:0];
          jlp_pkg::OFS_JERK: jerk_r <= reg_wdata[JW-1:0];
          jlp_pkg::OFS_VSTART: vstart_r <= reg_wdata[VW-1:0];
          jlp_pkg::OFS_VTARGET: vtarget_r <= reg_wdata[VW-1:0];
          jlp_pkg::OFS_CTRL: begin
            // Stop wins when both bits are set
            if (reg_wdata[jlp_pkg::CTRL_STOP_BIT]) begin
              goal_r <= vstart_r;
              go_r <= 1'b1;
            end else if (reg_wdata[jlp_pkg::CTRL_GO_BIT]) begin
              goal_r <= vtarget_r;
              go_r <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        jlp_pkg::OFS_ACCEL: reg_rdata <= 32'(accel_r);
        jlp_pkg::OFS_DECEL: reg_rdata <= 32'(decel_r);
        jlp_pkg::OFS_JERK: reg_rdata <= 32'(jerk_r);
        jlp_pkg::OFS_VSTART: reg_rdata <= 32'(vstart_r);
        jlp_pkg::OFS_VTARGET: reg_rdata <= 32'(vtarget_r);
        jlp_pkg::OFS_STATUS: begin
          reg_rdata <= 32'h0;
          reg_rdata[jlp_pkg::STAT_BUSY_BIT] <= busy;
          reg_rdata[jlp_pkg::STAT_TRAP_BIT] <= trap_r;
          reg_rdata[jlp_pkg::STAT_DOWN_BIT] <= dir_dn_r;
        end
        jlp_pkg::OFS_SPEED: reg_rdata <= 32'(step_rate);
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ==========================================================
  // Phase arithmetic
  // Slowing phases take the decel rate, speeding phases the accel
  assign rate_sel = dir_dn_r ? decel_r : accel_r;
  assign jprod = jerk_r * rate_sel;
  assign spd_s = dir_dn_r ? base_r - prog_r : base_r + prog_r;

  // ==========================================================
  // Profile engine; acc_r is accel*F, prog_r is speed change*F*F
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= jlp_pkg::JLP_IDLE;
      dir_dn_r <= 1'b0;
      trap_r <= 1'b0;
      j_r <= '0;
      amax_r <= '0;
      acc_r <= '0;
      prog_r <= '0;
      dv_r <= '0;
      half_r <= '0;
      p1_r <= '0;
      base_r <= '0;
    end else begin
      unique case (state_r)
        jlp_pkg::JLP_IDLE: begin
          if (go_r) begin
            // New command restarts from the present speed
            dir_dn_r <= goal_r < step_rate;
            base_r <= PW'(step_rate) << SH;
            dv_r <= goal_r < step_rate ? PW'(step_rate - goal_r) << SH
                                       : PW'(goal_r - step_rate) << SH;
            half_r <= goal_r < step_rate ? PW'(step_rate - goal_r) << (SH - 1)
                                         : PW'(goal_r - step_rate) << (SH - 1);
            prog_r <= '0;
            acc_r <= '0;
            trap_r <= 1'b0;
            state_r <= jlp_pkg::JLP_LOAD;
          end
        end
        jlp_pkg::JLP_LOAD: begin
          j_r <= PW'(jprod / (JW+AW)'(jlp_pkg::JERK_SCALE));
          amax_r <= PW'(rate_sel) << jlp_pkg::TICK_SHIFT;
          if (dv_r == '0) begin
            state_r <= jlp_pkg::JLP_IDLE;
          end else if (jerk_r == '0) begin
            acc_r <= PW'(rate_sel) << jlp_pkg::TICK_SHIFT;
            state_r <= jlp_pkg::JLP_CONST;
          end else begin
            state_r <= jlp_pkg::JLP_UP;
          end
        end
        jlp_pkg::JLP_CONST: if (tick) begin
          // Full rate from the first update, no shaping
          if (prog_r + amax_r >= dv_r) begin
            prog_r <= dv_r;
            acc_r <= '0;
            state_r <= jlp_pkg::JLP_IDLE;
          end else begin
            prog_r <= prog_r + amax_r;
          end
        end
        jlp_pkg::JLP_UP: if (tick) begin
          if (acc_r + j_r >= amax_r) begin
            // Cap reached before midpoint: hold the rate
            acc_r <= amax_r;
            prog_r <= prog_r + amax_r;
            p1_r <= prog_r + amax_r;
            trap_r <= 1'b1;
            state_r <= jlp_pkg::JLP_HOLD;
          end else begin
            acc_r <= acc_r + j_r;
            prog_r <= prog_r + acc_r + j_r;
            p1_r <= prog_r + acc_r + j_r;
            // Midpoint reached under the cap: triangular
            if (prog_r + acc_r + j_r >= half_r) begin
              state_r <= jlp_pkg::JLP_DOWN;
            end
          end
        end
        jlp_pkg::JLP_HOLD: if (tick) begin
          // Leave the hold so the ramp-down covers what ramp-up did
          if (prog_r >= dv_r - p1_r) begin
            state_r <= jlp_pkg::JLP_DOWN;
          end else begin
            prog_r <= prog_r + amax_r;
          end
        end
        jlp_pkg::JLP_DOWN: if (tick) begin
          // Mirror of the ramp-up; final step snaps onto the goal
          if (acc_r <= j_r || prog_r + acc_r - j_r >= dv_r) begin
            prog_r <= dv_r;
            acc_r <= '0;
            state_r <= jlp_pkg::JLP_IDLE;
          end else begin
            acc_r <= acc_r - j_r;
            prog_r <= prog_r + acc_r - j_r;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Output rate and busy flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_rate <= '0;
      busy <= 1'b0;
    end else begin
      step_rate <= spd_s[SH+VW-1:SH];
      busy <= state_r != jlp_pkg::JLP_IDLE;
    end
  end

  // ==========================================================
  // Step pulses: phase accumulator wraps at the clock rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_r <= '0;
      step_pulse <= 1'b0;
    end else if (ph_r + PH'(step_rate) >= PH'(jlp_pkg::CLK_HZ)) begin
      ph_r <= ph_r + PH'(step_rate) - PH'(jlp_pkg::CLK_HZ);
      step_pulse <= 1'b1;
    end else begin
      ph_r <= ph_r + PH'(step_rate);
      step_pulse <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_ramp_tick;
    state_r == jlp_pkg::JLP_UP && tick && acc_r + j_r < amax_r;
  endsequence

  a_jerk_scale: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == jlp_pkg::JLP_LOAD |=> j_r == PW'($past(jprod) / 100))
    else $error("jerk not parameter times rate over 100");
  a_zero_jerk: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == jlp_pkg::JLP_CONST && tick && prog_r + amax_r < dv_r
    |=> prog_r == $past(prog_r) + $past(amax_r) && acc_r == amax_r)
    else $error("zero jerk phase not at constant rate");
  a_ramp_down: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == jlp_pkg::JLP_DOWN && tick && acc_r > j_r
    && prog_r + acc_r - j_r < dv_r |=> acc_r == $past(acc_r) - $past(j_r))
    else $error("ramp-down not mirroring ramp-up");
  a_ramp_up: assert property (@(posedge clk) disable iff (!rst_n)
    s_ramp_tick |=> acc_r == $past(acc_r) + $past(j_r)
    && prog_r == $past(prog_r) + acc_r)
    else $error("acceleration not rising by jerk");
  a_tri_shape: assert property (@(posedge clk) disable iff (!rst_n)
    s_ramp_tick ##0 (prog_r + acc_r + j_r >= half_r)
    |=> state_r == jlp_pkg::JLP_DOWN && !trap_r)
    else $error("triangular curve did not turn at midpoint");
  a_trap_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == jlp_pkg::JLP_HOLD |-> acc_r == amax_r && trap_r)
    else $error("hold segment not at capped rate");
  a_cap_limit: assert property (@(posedge clk) disable iff (!rst_n)
    state_r != jlp_pkg::JLP_LOAD |-> acc_r <= amax_r)
    else $error("acceleration above programmed rate");
  a_same_shape: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == jlp_pkg::JLP_LOAD && accel_r == decel_r
    |=> amax_r == PW'($past(accel_r)) << jlp_pkg::TICK_SHIFT)
    else $error("equal rates give different shape");
  a_decel_rate: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == jlp_pkg::JLP_LOAD && dir_dn_r
    |=> amax_r == PW'($past(decel_r)) << jlp_pkg::TICK_SHIFT)
    else $error("slowing phase not using decel rate");
endmodule
`default_nettype wire

//--- verilog/jlp_tick.sv
`timescale 1ns/1ps
`default_nettype none
module jlp_tick #(
  parameter int DIV = jlp_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Update strobe
  output logic tick
);
  logic [31:0] cnt_r;

  // ==========================================================
  // Divider: one-cycle enable every DIV cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r == 32'(DIV - 1)) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire
